// >>> core/fsp_pkg.sv
// shared constants, types and helpers of the flash self-program sequencer
package fsp_pkg;
  // ----------------------------------------------------------------
  // flash geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 6;
  localparam int unsigned PAGE_BITS = 7;
  localparam int unsigned Z_WORD_LSB = 1;
  localparam int unsigned Z_PAGE_LSB = 7;
  localparam logic [6:0] HALT_FIRST_PAGE = 7'h70;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_REEN = 4;
  localparam int unsigned BIT_BUSY = 6;
  localparam int unsigned BIT_IRQ_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] PAT_NONE = 5'h00;
  localparam logic [4:0] PAT_LOAD = 5'h01;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_REEN = 5'h11;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_US_MIN = 3700;
  localparam int unsigned PROG_TIME_US_MAX = 4500;
  localparam int unsigned PROG_CYCLES_MIN = PROG_TIME_US_MIN * CLK_MHZ;
  localparam int unsigned PROG_CNT_W = 19;
  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ZPTR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam int unsigned ST_SEQ = 8;
  localparam int unsigned ST_HALT = 9;
  localparam int unsigned ST_LIVE = 10;
  localparam int unsigned ST_IRQ = 11;
  typedef enum logic [2:0] {
    OP_IRQ, OP_LOAD, OP_ERASE, OP_WRITE, OP_REEN, OP_LOCK
  } fsp_op_t;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] z_page(input logic [15:0] z);
    z_page = z[Z_PAGE_LSB +: PAGE_BITS];
  endfunction
  function automatic logic [5:0] z_word(input logic [15:0] z);
    z_word = z[Z_WORD_LSB +: WORD_BITS];
  endfunction
  function automatic logic is_halting(input logic [6:0] page);
    is_halting = page >= HALT_FIRST_PAGE;
  endfunction
  function automatic logic valid_pattern(input logic [4:0] p);
    valid_pattern = p == PAT_LOAD || p == PAT_ERASE || p == PAT_WRITE ||
      p == PAT_LOCK || p == PAT_REEN;
  endfunction
  function automatic logic [4:0] op_pattern(input fsp_op_t op);
    case (op)
      OP_LOAD: op_pattern = PAT_LOAD;
      OP_ERASE: op_pattern = PAT_ERASE;
      OP_WRITE: op_pattern = PAT_WRITE;
      OP_REEN: op_pattern = PAT_REEN;
      OP_LOCK: op_pattern = PAT_LOCK;
      default: op_pattern = PAT_NONE;
    endcase
  endfunction
endpackage

// >>> core/fsp_if.sv
// link between the cpu end and the sequencer end
`timescale 1ns/1ps
interface fsp_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic store_strobe;
  logic [15:0] zptr;
  logic [15:0] data_pair;
  logic ee_write;
  logic irq;
  logic cpu_halt;
  logic live_block;
  modport dev (
    input ctrl_wr, ctrl_wdata, store_strobe, zptr, data_pair, ee_write,
    output ctrl_rdata, irq, cpu_halt, live_block
  );
  modport cpu (
    output ctrl_wr, ctrl_wdata, store_strobe, zptr, data_pair, ee_write,
    input ctrl_rdata, irq, cpu_halt, live_block
  );
endinterface

// >>> core/fsp_page_buffer.sv
// temporary page buffer with per-word written marks
`timescale 1ns/1ps
module fsp_page_buffer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr,
  input wire logic [5:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:63];
  logic [63:0] written;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // a location already written is kept; rewriting is not supported
  wire wr_take = wr && !written[wr_addr]; // RL7

  always_ff @(posedge ref_clk) begin
    if (wr_take) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // marks clear at reset, so unwritten words read as erased
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      written <= 64'h0; // RL6
    end else if (clear) begin
      written <= 64'h0; // RL6
    end else if (wr_take) begin
      written[wr_addr] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= fsp_pkg::ERASED_WORD;
    end else begin
      rd_data <= written[rd_addr] ? mem[rd_addr] : fsp_pkg::ERASED_WORD;
    end
  end
endmodule

// >>> core/fsp_device.sv
// sequencer end: control register, arming window, program timer, buffer
// Operation
// RL1: erase command, store within four cycles
// RL2: erase pointer holds page index only
// RL3: live erase keeps halting region; halting stalls
// RL4: load command stores data pair word
// RL5: word index field selects buffer word
// RL6: buffer clears on write, reenable, reset
// RL7: each buffer word written once only
// RL8: eeprom write during load drops words
// RL9: page write command, page index only
// RL10: live write readable; halting write stalls
// RL11: irq held while enabled and enable clear
// RL12: vectors in boot section or irqs off
// RL13: program boot update lock when possible
// RL14: live region unreadable during erase/write
// RL15: busy flag set while live region occupied
// RL16: software reenables before touching live region
// RL17: enable arms four cycles, held during operation
// RL18: busy set on start, cleared reenable/load
// RL19: only five command patterns take effect
// RL20: erase and write timed 3.7 to 4.5 ms
// RL21: page and command latched at start
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fsp_device #(
  parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES_MIN
) (
  input wire logic ref_clk,
  input wire logic resetn,
  fsp_if.dev bus,
  input wire logic [5:0] buf_rd_addr,
  output logic [15:0] buf_rd_data,
  output logic flash_erase,
  output logic flash_write,
  output logic [6:0] flash_page,
  output logic op_done
);
  logic irq_en;
  logic busy_flag;
  logic [4:0] cmd;
  logic [2:0] arm_cnt;
  logic [fsp_pkg::PROG_CNT_W-1:0] prog_cnt;
  logic halt_q;
  logic irq_q;
  logic load_active;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire op_run = flash_erase || flash_write;
  // control writes are ignored while an erase or write runs
  wire wr_ok = bus.ctrl_wr && !op_run;
  wire accept = wr_ok && fsp_pkg::valid_pattern(bus.ctrl_wdata[4:0]); // RL19
  wire armed = cmd[fsp_pkg::BIT_ENABLE] && !op_run &&
    arm_cnt != 3'h0; // RL17
  wire store_go = bus.store_strobe && armed; // RL1
  wire is_load = cmd == fsp_pkg::PAT_LOAD;
  wire is_erase = cmd == fsp_pkg::PAT_ERASE;
  wire is_write = cmd == fsp_pkg::PAT_WRITE;
  wire is_reen = cmd == fsp_pkg::PAT_REEN;
  // data pair is not looked at for erase or write
  wire start_op = store_go && (is_erase || is_write); // RL1 RL9
  wire do_load = store_go && is_load; // RL4
  wire do_reen = store_go && is_reen;
  wire timeout = armed && !bus.store_strobe && arm_cnt == 3'h1; // RL17
  wire prog_end = op_run && prog_cnt == 1; // RL20
  wire [6:0] z_page = fsp_pkg::z_page(bus.zptr); // RL2 RL9
  wire [5:0] z_word = fsp_pkg::z_word(bus.zptr); // RL5
  wire z_halting = fsp_pkg::is_halting(z_page);
  wire reen_written = accept &&
    bus.ctrl_wdata[4:0] == fsp_pkg::PAT_REEN;
  wire ee_abort = bus.ee_write && load_active; // RL8
  wire buf_clear = (prog_end && flash_write) || reen_written ||
    ee_abort; // RL6 RL8
  // a word arriving with an eeprom write is part of the lost load
  wire buf_wr = do_load && !bus.ee_write; // RL8
  // a page operation keeps the command until its timer runs out
  wire cmd_done = prog_end || timeout || (store_go && !start_op); // RL17

  // ----------------------------------------------------------------
  // temporary page buffer
  // ----------------------------------------------------------------
  fsp_page_buffer u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clear(buf_clear),
    .wr(buf_wr),
    .wr_addr(z_word), // RL5
    .wr_data(bus.data_pair), // RL4
    .rd_addr(buf_rd_addr),
    .rd_data(buf_rd_data)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_en <= fsp_pkg::CTRL_RESET[fsp_pkg::BIT_IRQ_EN];
    end else if (wr_ok) begin
      irq_en <= bus.ctrl_wdata[fsp_pkg::BIT_IRQ_EN];
    end
  end

  // enable and command bits stay set through the whole operation
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= fsp_pkg::CTRL_RESET[4:0];
    end else if (accept) begin
      cmd <= bus.ctrl_wdata[4:0];
    end else if (cmd_done) begin
      cmd <= fsp_pkg::PAT_NONE; // RL17
    end
  end

  // the window only counts while the enable bit waits for a store
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arm_cnt <= 3'h0;
    end else if (accept) begin
      arm_cnt <= fsp_pkg::ARM_CYCLES; // RL17
    end else if (store_go || timeout) begin
      arm_cnt <= 3'h0;
    end else if (armed) begin
      arm_cnt <= arm_cnt - 3'h1;
    end
  end

  // set on a live-region start; clear on reenable store or a load
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_flag <= fsp_pkg::CTRL_RESET[fsp_pkg::BIT_BUSY];
    end else if (start_op && !z_halting) begin
      busy_flag <= 1'b1; // RL15 RL18
    end else if (do_reen || do_load) begin
      busy_flag <= 1'b0; // RL18
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_active <= 1'b0;
    end else if (buf_clear) begin
      load_active <= 1'b0;
    end else if (buf_wr) begin
      load_active <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // program timer and latched operation
  // ----------------------------------------------------------------
  // one fixed duration at the short bound keeps the cpu waiting least
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prog_cnt <= '0;
    end else if (start_op) begin
      prog_cnt <= PROG_CYCLES[fsp_pkg::PROG_CNT_W-1:0]; // RL20
    end else if (op_run) begin
      prog_cnt <= prog_cnt - 1'b1;
    end
  end

  // kind and page are held, so the pointer is free once a run starts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page <= 7'h00;
      halt_q <= 1'b0;
    end else if (start_op) begin
      flash_erase <= is_erase; // RL21
      flash_write <= is_write; // RL21
      flash_page <= z_page; // RL21
      halt_q <= z_halting; // RL3 RL10
    end else if (prog_end) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      halt_q <= 1'b0; // RL3 RL10
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op_done <= 1'b0;
    end else begin
      op_done <= prog_end;
    end
  end

  // irq lags the enable bit by a cycle; it stays up while software idles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en && !cmd[fsp_pkg::BIT_ENABLE]; // RL11
    end
  end

  // ----------------------------------------------------------------
  // outputs to the cpu
  // ----------------------------------------------------------------
  assign bus.ctrl_rdata = {irq_en, busy_flag, 1'b0, cmd}; // RL15
  assign bus.irq = irq_q; // RL11
  // stall only for halting-region targets; live ops leave it running
  assign bus.cpu_halt = halt_q; // RL3 RL10
  // busy flag alone blocks, so the block lasts until a reenable or load store
  assign bus.live_block = busy_flag; // RL14
endmodule

// >>> core/fsp_cpu_end.sv
// cpu end: register port, store-program sequence, guarded fetches
`timescale 1ns/1ps
module fsp_cpu_end (
  input wire logic ref_clk,
  input wire logic resetn,
  fsp_if.cpu bus,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic ee_write,
  input wire logic fetch_req,
  input wire logic [12:0] fetch_addr,
  output logic fetch_grant,
  output logic fetch_refused
);
  typedef enum logic [1:0] {S_IDLE, S_CTRL, S_STORE, S_WAIT} fsp_state_t;
  fsp_state_t state;
  fsp_pkg::fsp_op_t op;
  logic irq_en;
  logic [15:0] zreg;
  logic [15:0] dreg;
  logic ctrl_wr_q;
  logic [7:0] ctrl_wdata_q;
  logic store_q;
  logic [15:0] zptr_q;
  logic ee_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire idle = state == S_IDLE;
  // a command while a sequence runs is dropped; status shows busy
  wire cmd_wr = wr && addr == fsp_pkg::REG_CMD && idle;
  wire page_op = op == fsp_pkg::OP_ERASE || op == fsp_pkg::OP_WRITE;
  wire [15:0] page_only = {2'b00, fsp_pkg::z_page(zreg), 7'h00}; // RL2
  wire [15:0] z_out = page_op ? page_only :
    (op == fsp_pkg::OP_LOAD ? zreg : 16'h0000); // RL2 RL9
  wire [15:0] status = {4'h0, bus.irq, bus.live_block, bus.cpu_halt,
    !idle, bus.ctrl_rdata};
  wire [6:0] fetch_page = fetch_addr[fsp_pkg::WORD_BITS +:
    fsp_pkg::PAGE_BITS];
  // live region fetches are refused while the block lasts
  wire fetch_ok = !bus.cpu_halt && !(bus.live_block &&
    !fsp_pkg::is_halting(fetch_page)); // RL14 RL16 RL12

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      zreg <= 16'h0000;
      dreg <= 16'h0000;
      irq_en <= 1'b0;
      op <= fsp_pkg::OP_IRQ;
    end else if (wr && addr == fsp_pkg::REG_ZPTR) begin
      zreg <= wdata;
    end else if (wr && addr == fsp_pkg::REG_DATA) begin
      dreg <= wdata;
    end else if (cmd_wr) begin
      irq_en <= wdata[fsp_pkg::BIT_IRQ_EN];
      op <= fsp_pkg::fsp_op_t'(wdata[2:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (rd && addr == fsp_pkg::REG_STATUS) begin
      rdata <= status;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // store-program sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      ctrl_wr_q <= 1'b0;
      ctrl_wdata_q <= fsp_pkg::CTRL_RESET;
      store_q <= 1'b0;
      zptr_q <= 16'h0000;
    end else begin
      ctrl_wr_q <= 1'b0;
      store_q <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            state <= S_CTRL;
          end
        end
        S_CTRL: begin
          ctrl_wr_q <= 1'b1;
          ctrl_wdata_q <= {irq_en, 2'b00, fsp_pkg::op_pattern(op)}; // RL13
          zptr_q <= z_out;
          state <= op == fsp_pkg::OP_IRQ ? S_IDLE : S_STORE;
        end
        S_STORE: begin
          store_q <= 1'b1; // RL1 RL4 RL9
          state <= S_WAIT;
        end
        default: begin
          // enable bit drops when the device is done
          if (!bus.ctrl_rdata[fsp_pkg::BIT_ENABLE]) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ee_q <= 1'b0;
      fetch_grant <= 1'b0;
      fetch_refused <= 1'b0;
    end else begin
      ee_q <= ee_write;
      fetch_grant <= fetch_req && fetch_ok;
      fetch_refused <= fetch_req && !fetch_ok;
    end
  end

  assign bus.ctrl_wr = ctrl_wr_q;
  assign bus.ctrl_wdata = ctrl_wdata_q;
  assign bus.store_strobe = store_q;
  assign bus.zptr = zptr_q;
  assign bus.data_pair = dreg;
  assign bus.ee_write = ee_q;
endmodule

// >>> verif/fsp_link_chk.sv
// link checker for the flash self-program sequencer
`timescale 1ns/1ps
module fsp_link_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic store_strobe,
  input wire logic [15:0] zptr,
  input wire logic [15:0] data_pair,
  input wire logic ee_write,
  input wire logic irq,
  input wire logic cpu_halt,
  input wire logic live_block
);
  // ----------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  wire [4:0] cmd = ctrl_rdata[4:0];
  wire idle = !ctrl_rdata[0];
  wire pat_ok = ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
  wire prog_st = store_strobe && !idle && (cmd == 5'h03 || cmd == 5'h05);
  wire halt_pg = zptr[13:7] >= 7'h70;
  wire clr_st = store_strobe && !idle && !ee_write &&
    (cmd == 5'h01 || cmd == 5'h11);
  // counts halt cycles; a repetition would be far too long to unroll
  logic [19:0] run_cnt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_cnt <= 20'h0;
    end else begin
      run_cnt <= cpu_halt ? run_cnt + 20'h1 : 20'h0;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  busy_hold_a: assert property (live_block &&
    (cmd == 5'h03 || cmd == 5'h05) |=> live_block)
    else $error("busy flag dropped during live operation");
  irq_on_a: assert property (ctrl_rdata[7] && idle |=> irq)
    else $error("irq missing while enabled and idle");
  irq_off_a: assert property (!ctrl_rdata[7] || !idle |=> !irq)
    else $error("irq raised while disabled or busy");
  cmd_take_a: assert property (ctrl_wr && idle && pat_ok |=>
    cmd == $past(ctrl_wdata[4:0]) && ctrl_rdata[7] == $past(ctrl_wdata[7]))
    else $error("valid command not stored");
  cmd_drop_a: assert property (ctrl_wr && idle && !pat_ok |=>
    $stable(cmd))
    else $error("invalid command changed control bits");
  halt_start_a: assert property (prog_st && halt_pg |=> cpu_halt)
    else $error("halting page op did not stall");
  live_start_a: assert property (prog_st && !halt_pg |=>
    live_block && !cpu_halt)
    else $error("live page op did not block live region");
  halt_hold_a: assert property (cpu_halt |-> !idle && cmd != 5'h00)
    else $error("enable dropped during operation");
  halt_len_a: assert property ($fell(cpu_halt) |->
    run_cnt == PROG_CYCLES && cmd == 5'h00)
    else $error("operation length or end wrong");
  busy_clear_a: assert property (clr_st |=> !live_block)
    else $error("busy flag not cleared by load or reenable");
  // ----------------------------------------------------------------
  // cover
  // ----------------------------------------------------------------
  halt_op_c: cover property (prog_st && halt_pg);
  live_op_c: cover property (prog_st && !halt_pg);
  irq_c: cover property (irq);
  clear_c: cover property (clr_st && live_block);
endmodule

// >>> verif/tb_flash_self_program_sequencer.sv
// self-checking bench joining the cpu end and the sequencer end
`timescale 1ns/1ps
module tb_flash_self_program_sequencer;
  localparam int unsigned PC = 20;
  typedef struct packed {
    logic [2:0] op;
    logic [15:0] z;
    logic [15:0] d;
    logic [5:0] w;
    logic [15:0] exp;
  } fsp_row_t;
  logic ref_clk = 1'b0;
  logic resetn;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic ee_write;
  logic fetch_req;
  logic [12:0] fetch_addr;
  logic fetch_grant;
  logic fetch_refused;
  logic [5:0] buf_rd_addr;
  logic [15:0] buf_rd_data;
  logic flash_erase;
  logic flash_write;
  logic [6:0] flash_page;
  logic op_done;
  int miscompares = 0;
  int n_checks = 0;
  int prog_len = 0;
  int n_done = 0;
  fsp_row_t rows [5] = '{
    '{3'h1, 16'h0000, 16'h1234, 6'h00, 16'h1234},
    '{3'h1, 16'h007e, 16'habcd, 6'h3f, 16'habcd},
    '{3'h1, 16'h000b, 16'h5a5a, 6'h05, 16'h5a5a},
    '{3'h5, 16'h0000, 16'h00ff, 6'h00, 16'h1234},
    '{3'h0, 16'h0000, 16'h0000, 6'h3f, 16'habcd}};
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (flash_erase || flash_write) prog_len <= prog_len + 1;
    if (op_done) n_done <= n_done + 1;
  end
  fsp_if link();
  fsp_device #(.PROG_CYCLES(PC)) u_fsp_device (
    .ref_clk(ref_clk), .resetn(resetn), .bus(link),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_page(flash_page), .op_done(op_done));
  fsp_cpu_end u_fsp_cpu_end (
    .ref_clk(ref_clk), .resetn(resetn), .bus(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ee_write(ee_write),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_grant(fetch_grant), .fetch_refused(fetch_refused));
  fsp_link_chk #(.PROG_CYCLES(PC)) u_fsp_link_chk (
    .ref_clk(ref_clk), .resetn(resetn), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
    .store_strobe(link.store_strobe), .zptr(link.zptr),
    .data_pair(link.data_pair), .ee_write(link.ee_write), .irq(link.irq),
    .cpu_halt(link.cpu_halt), .live_block(link.live_block));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // polls are bounded so a stuck sequence ends the run
  task automatic wait_bit(input int i, input logic v);
    logic [15:0] s;
    int k;
    for (k = 0; k < 60; k++) begin
      rd_reg(fsp_pkg::REG_STATUS, s);
      if (s[i] === v) return;
    end
    miscompares++;
    $display("wrong value status bit %0d expected %b seen %b", i, v, s[i]);
    wrap_up();
  endtask
  task automatic st_bit(input int i, input logic v);
    logic [15:0] s;
    rd_reg(fsp_pkg::REG_STATUS, s);
    chk("status bit", {15'h0, v}, {15'h0, s[i]});
  endtask
  task automatic do_cmd(input logic [2:0] op, input logic [15:0] z,
                        input logic [15:0] d, input logic ie);
    wr_reg(fsp_pkg::REG_ZPTR, z);
    wr_reg(fsp_pkg::REG_DATA, d);
    wr_reg(fsp_pkg::REG_CMD, {8'h00, ie, 4'h0, op});
    // page operations return at once so checks can run while they last
    if (op != 3'h2 && op != 3'h3) begin
      wait_bit(fsp_pkg::ST_SEQ, 1'b0);
    end
  endtask
  task automatic rd_buf(input logic [5:0] w, input logic [15:0] e);
    @(posedge ref_clk);
    buf_rd_addr <= w;
    @(posedge ref_clk);
    #1 chk("buffer word", e, buf_rd_data);
  endtask
  task automatic fetch(input logic [6:0] pg, input logic refused);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= {pg, 6'h00};
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    #1 chk("fetch refused", {15'h0, refused}, {15'h0, fetch_refused});
    chk("fetch grant", {15'h0, !refused}, {15'h0, fetch_grant});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    ee_write = 1'b0;
    fetch_req = 1'b0;
    fetch_addr = 13'h0000;
    buf_rd_addr = 6'h00;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      do_cmd(rows[i].op, rows[i].z, rows[i].d, 1'b0);
      wait_bit(0, 1'b0);
      rd_buf(rows[i].w, rows[i].exp);
    end
    $display("test table done");
    do_cmd(3'h1, 16'h000a, 16'h0bad, 1'b0);
    wait_bit(0, 1'b0);
    rd_buf(6'h05, 16'h5a5a);
    $display("test second load done");
    prog_len = 0;
    do_cmd(3'h3, 16'h0800, 16'h0000, 1'b0);
    wait_bit(fsp_pkg::ST_LIVE, 1'b1);
    fetch(7'h10, 1'b1);
    fetch(7'h70, 1'b0);
    chk("write running", 16'h0001, {15'h0, flash_write});
    wr_reg(fsp_pkg::REG_ZPTR, 16'h1f80);
    chk("latched page", 16'h0010, {9'h0, flash_page});
    wait_bit(0, 1'b0);
    chk("program cycles", PC[15:0], prog_len[15:0]);
    rd_buf(6'h05, fsp_pkg::ERASED_WORD);
    st_bit(fsp_pkg::ST_LIVE, 1'b1);
    $display("test live write done");
    do_cmd(3'h4, 16'h0000, 16'h0000, 1'b0);
    wait_bit(0, 1'b0);
    st_bit(fsp_pkg::ST_LIVE, 1'b0);
    do_cmd(3'h1, 16'h0004, 16'h2222, 1'b0);
    wait_bit(0, 1'b0);
    rd_buf(6'h02, 16'h2222);
    do_cmd(3'h4, 16'h0000, 16'h0000, 1'b0);
    wait_bit(0, 1'b0);
    rd_buf(6'h02, fsp_pkg::ERASED_WORD);
    $display("test reenable done");
    prog_len = 0;
    do_cmd(3'h2, 16'h3800, 16'h0000, 1'b1);
    wait_bit(fsp_pkg::ST_HALT, 1'b1);
    st_bit(fsp_pkg::ST_IRQ, 1'b0);
    fetch(7'h70, 1'b1);
    chk("erase running", 16'h0001, {15'h0, flash_erase});
    wait_bit(0, 1'b0);
    chk("program cycles", PC[15:0], prog_len[15:0]);
    chk("done pulses", 16'h0002, n_done[15:0]);
    st_bit(fsp_pkg::ST_IRQ, 1'b1);
    do_cmd(3'h0, 16'h0000, 16'h0000, 1'b0);
    wait_bit(0, 1'b0);
    st_bit(fsp_pkg::ST_IRQ, 1'b0);
    $display("test halting erase done");
    do_cmd(3'h1, 16'h0002, 16'h1111, 1'b0);
    wait_bit(0, 1'b0);
    @(posedge ref_clk);
    ee_write <= 1'b1;
    @(posedge ref_clk);
    ee_write <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_buf(6'h01, fsp_pkg::ERASED_WORD);
    $display("test eeprom abort done");
    do_cmd(3'h1, 16'h0006, 16'h3333, 1'b0);
    wait_bit(0, 1'b0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    #1 chk("buffer in reset", fsp_pkg::ERASED_WORD, buf_rd_data);
    @(posedge ref_clk);
    resetn <= 1'b1;
    rd_buf(6'h03, fsp_pkg::ERASED_WORD);
    st_bit(0, 1'b0);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
